// *** design/core_regs.vh ***
/*
 Register offsets, field positions and reset values of the core register state.
 Assumes inclusion by core register modules only; byte addresses of the data space.
*/
`ifndef CORE_REGS_VH
`define CORE_REGS_VH

`define WREG_BASE        16'h0000
`define WREG_LAST        16'h001E
`define WREG_STACK_IDX   4'hF
`define ACC_A_LOW        16'h0022
`define ACC_A_HIGH       16'h0024
`define ACC_A_UPPER      16'h0026
`define ACC_B_LOW        16'h0028
`define ACC_B_HIGH       16'h002A
`define ACC_B_UPPER      16'h002C
`define PC_LOW           16'h002E
`define PC_HIGH          16'h0030
`define LOOP_START_LOW   16'h003A
`define LOOP_START_HIGH  16'h003C
`define CORE_CONTROL     16'h0044

`define CC_MULT_INT_BIT  0
`define CC_ROUND_BIT     1
`define CC_FRAME_BIT     2
`define CC_PRIO_MSB_BIT  3
`define CC_ROUND_RESET   1'h0
`define CC_MULT_RESET    1'h0
`define PC_RESET         23'h000000
`define PC_STEP          23'h000002
`define PRIO_THRESHOLD   4'h7

`endif

// *** design/work_reg_mem.v ***
/*
 Working register storage: a primary set of sixteen words and two alternate sets.
 Assumes the caller forms the flat word index; read data come out of a register.
*/
`timescale 1ns/100ps
module work_reg_mem
#(
	parameter DATA_W = 16,
	parameter ADDR_W = 6,
	parameter DEPTH  = 48
)
(
	// Clock
	input  wire              clk,
	input  wire              clkEn,
	// Access
	input  wire [ADDR_W-1:0] addr,
	input  wire              wrEn,
	input  wire [DATA_W-1:0] wrData,
	output reg  [DATA_W-1:0] rdData
);

	reg [DATA_W-1:0] mem [0:DEPTH-1];

	always @(posedge clk)
	begin
		if (clkEn)
		begin
			if (wrEn)
				mem[addr] <= wrData;
			rdData <= mem[addr];
		end
	end

endmodule // work_reg_mem

// *** design/cpu_core_register_state.v ***
/*
 Architectural register state of a 16-bit signal-processing core: working registers with two
 shadow contexts, two 40-bit accumulators, program counter, loop start and core control bits.
 Assumes instruction-side data accesses arrive as one-cycle strobes on the data port and that
 the interrupt logic, loop hardware and DSP engine drive their own load inputs.
*/
// Notes on behaviour
// - Every register here except the priority level and stack page outputs is reachable through the data-space port by ordinary accesses.
// - Sixteen primary working registers plus two alternate sets of fifteen shadow registers.
// - Data access to the lower fifteen working registers uses the active context.
// - Two independent 40-bit signal-processing accumulators.
// - Program counter is 23 bits wide.
// - Loop start halves are read-only; software writes leave them unchanged.
// - Core control bit 3 reads 1 when priority level exceeds 7.
// - Full priority level is the MSB placed above the three status priority bits.
// - Stack frame active makes frame and stack pointers ignore the page registers.
// - Core control bit 1 selects biased rounding when 1, convergent when 0.
// - Core control bit 0 selects integer multiply when 1, fractional when 0.
`timescale 1ns/100ps
`include "core_regs.vh"
module cpu_core_register_state
#(
	parameter DATA_W = 16,
	parameter ACC_W  = 40,
	parameter PC_W   = 23,
	parameter PAGE_W = 10
)
(
	// Clock and reset
	input  wire              clk,
	input  wire              sys_rst,
	input  wire              clkEn,
	// Data-space access by instructions
	input  wire [15:0]       memAddr,
	input  wire              memWr,
	input  wire              memRd,
	input  wire [DATA_W-1:0] memWrData,
	output reg  [DATA_W-1:0] memRdData,
	output reg               memRdValid,
	// Context and interrupt state
	input  wire [1:0]        contextSel,
	input  wire              priority_level_msb,
	input  wire [2:0]        priority_level_low,
	output reg  [3:0]        priorityLevel,
	// Stack frame and data-space pages
	input  wire              stack_frame_active,
	input  wire [PAGE_W-1:0] eds_read_page,
	input  wire [PAGE_W-1:0] eds_write_page,
	output reg  [PAGE_W-1:0] stackReadPage,
	output reg  [PAGE_W-1:0] stackWritePage,
	// DSP engine
	input  wire              accWrA,
	input  wire              accWrB,
	input  wire [ACC_W-1:0]  accIn,
	output reg  [ACC_W-1:0]  accumulator_a,
	output reg  [ACC_W-1:0]  accumulator_b,
	output reg               roundBiased,
	output reg               multInteger,
	// Program flow
	input  wire              pcLoad,
	input  wire              pcStep,
	input  wire [PC_W-1:0]   pcIn,
	output reg  [PC_W-1:0]   programCounter,
	input  wire              loopLoad,
	input  wire [PC_W-1:0]   loopStartIn
);

	localparam WORD_W = 6;

	reg  [PC_W-1:0]   loopStart_r;
	reg               prioMsb_r;
	reg               frameActive_r;
	reg               readPend_r;
	reg               readFromMem_r;
	reg  [DATA_W-1:0] otherData_r;
	reg  [DATA_W-1:0] otherData_nxt;
	wire [DATA_W-1:0] memQ;
	wire [WORD_W-1:0] wordIdx;
	wire              wregWr;
	wire [DATA_W-1:0] coreControlView;

	// True when the byte address falls on a working register word.
	function isWorkReg;
		input [15:0] a;
		begin
			isWorkReg = (a <= `WREG_LAST) && (a[0] == 1'b0);
		end
	endfunction

	// Lower fifteen registers follow the active context, the stack pointer is shared.
	function [WORD_W-1:0] flatIndex;
		input [15:0] a;
		input [1:0]  ctx;
		reg   [3:0]  idx;
		reg   [1:0]  set;
		begin
			idx = a[4:1];
			set = (ctx == 2'h3) ? 2'h0 : ctx;
			if (idx == `WREG_STACK_IDX)
				flatIndex = {2'h0, idx};
			else
				flatIndex = {set, idx};
		end
	endfunction

	assign wordIdx = flatIndex(memAddr, contextSel);
	assign wregWr  = clkEn & memWr & isWorkReg(memAddr);

	work_reg_mem #(
		.DATA_W (DATA_W),
		.ADDR_W (WORD_W),
		.DEPTH  (48)
	) u_wregs (
		.clk    (clk),
		.clkEn  (clkEn),
		.addr   (wordIdx),
		.wrEn   (wregWr),
		.wrData (memWrData),
		.rdData (memQ)
	);

	assign coreControlView = {{(DATA_W-4){1'b0}}, prioMsb_r, frameActive_r, roundBiased, multInteger};

	// Read multiplexer for every data-space register held outside the working register memory.
	always @*
	begin
		otherData_nxt = {DATA_W{1'b0}};
		if (memAddr == `ACC_A_LOW)
			otherData_nxt = accumulator_a[15:0];
		else if (memAddr == `ACC_A_HIGH)
			otherData_nxt = accumulator_a[31:16];
		else if (memAddr == `ACC_A_UPPER)
			otherData_nxt = {{(DATA_W-(ACC_W-32)){accumulator_a[ACC_W-1]}}, accumulator_a[ACC_W-1:32]};
		else if (memAddr == `ACC_B_LOW)
			otherData_nxt = accumulator_b[15:0];
		else if (memAddr == `ACC_B_HIGH)
			otherData_nxt = accumulator_b[31:16];
		else if (memAddr == `ACC_B_UPPER)
			otherData_nxt = {{(DATA_W-(ACC_W-32)){accumulator_b[ACC_W-1]}}, accumulator_b[ACC_W-1:32]};
		else if (memAddr == `PC_LOW)
			otherData_nxt = programCounter[15:0];
		else if (memAddr == `PC_HIGH)
			otherData_nxt = {{(DATA_W-(PC_W-16)){1'b0}}, programCounter[PC_W-1:16]};
		else if (memAddr == `LOOP_START_LOW)
			otherData_nxt = loopStart_r[15:0];
		else if (memAddr == `LOOP_START_HIGH)
			otherData_nxt = {{(DATA_W-(PC_W-16)){1'b0}}, loopStart_r[PC_W-1:16]};
		else if (memAddr == `CORE_CONTROL)
			otherData_nxt = coreControlView;
	end

	// Two-stage read: memory word or side register, then the output flop.
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			readPend_r    <= 1'b0;
			readFromMem_r <= 1'b0;
			otherData_r   <= {DATA_W{1'b0}};
			memRdData     <= {DATA_W{1'b0}};
			memRdValid    <= 1'b0;
		end
		else if (clkEn)
		begin
			readPend_r    <= memRd;
			readFromMem_r <= isWorkReg(memAddr);
			otherData_r   <= otherData_nxt;
			memRdValid    <= readPend_r;
			if (readPend_r)
				memRdData <= readFromMem_r ? memQ : otherData_r;
		end
	end

	// Accumulators: the DSP engine update wins over a software word write.
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : g_acc
			wire [15:0] lowAddr = (g == 0) ? `ACC_A_LOW : `ACC_B_LOW;
			wire [15:0] highAddr = (g == 0) ? `ACC_A_HIGH : `ACC_B_HIGH;
			wire [15:0] upperAddr = (g == 0) ? `ACC_A_UPPER : `ACC_B_UPPER;
			wire        hwWr = (g == 0) ? accWrA : accWrB;
			reg  [ACC_W-1:0] acc_r;
			always @(posedge clk or posedge sys_rst)
			begin
				if (sys_rst)
					acc_r <= {ACC_W{1'b0}};
				else if (clkEn)
				begin
					if (hwWr)
						acc_r <= accIn;
					else if (memWr && memAddr == lowAddr)
						acc_r[15:0] <= memWrData;
					else if (memWr && memAddr == highAddr)
						acc_r[31:16] <= memWrData;
					else if (memWr && memAddr == upperAddr)
						acc_r[ACC_W-1:32] <= memWrData[ACC_W-33:0];
				end
			end
		end
	endgenerate

	always @*
	begin
		accumulator_a = g_acc[0].acc_r;
		accumulator_b = g_acc[1].acc_r;
	end

	// Program counter: hardware load, then step, then software word writes.
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			programCounter <= `PC_RESET;
		else if (clkEn)
		begin
			if (pcLoad)
				programCounter <= pcIn;
			else if (pcStep)
				programCounter <= programCounter + `PC_STEP;
			else if (memWr && memAddr == `PC_LOW)
				programCounter[15:0] <= {memWrData[15:1], 1'b0};
			else if (memWr && memAddr == `PC_HIGH)
				programCounter[PC_W-1:16] <= memWrData[PC_W-17:0];
		end
	end

	// Loop start is loaded only by the loop hardware; data-space writes are dropped.
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			loopStart_r <= `PC_RESET;
		else if (clkEn && loopLoad)
			loopStart_r <= loopStartIn;
	end

	// Core control bits, priority level and stack page selection.
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			roundBiased    <= `CC_ROUND_RESET;
			multInteger    <= `CC_MULT_RESET;
			prioMsb_r      <= 1'b0;
			frameActive_r  <= 1'b0;
			priorityLevel  <= 4'h0;
			stackReadPage  <= {PAGE_W{1'b0}};
			stackWritePage <= {PAGE_W{1'b0}};
		end
		else if (clkEn)
		begin
			if (memWr && memAddr == `CORE_CONTROL)
			begin
				roundBiased <= memWrData[`CC_ROUND_BIT];
				multInteger <= memWrData[`CC_MULT_INT_BIT];
			end
			prioMsb_r     <= priority_level_msb;
			frameActive_r <= stack_frame_active;
			priorityLevel <= {priority_level_msb, priority_level_low};
			stackReadPage  <= stack_frame_active ? {PAGE_W{1'b0}} : eds_read_page;
			stackWritePage <= stack_frame_active ? {PAGE_W{1'b0}} : eds_write_page;
		end
	end

endmodule // cpu_core_register_state

// *** tb/cpu_core_register_state_asserts.sv ***
/*
 Concurrent checks on the core register state ports.
 Assumes one clock, asynchronous active-high reset, bound to the top module.
*/
`timescale 1ns/100ps
module cpu_core_register_state_asserts
#(
	parameter DATA_W = 16,
	parameter ACC_W  = 40,
	parameter PC_W   = 23,
	parameter PAGE_W = 10
)
(
	input wire              clk,
	input wire              sys_rst,
	input wire              clkEn,
	input wire [15:0]       memAddr,
	input wire              memWr,
	input wire              memRd,
	input wire [DATA_W-1:0] memWrData,
	input wire              memRdValid,
	input wire              priority_level_msb,
	input wire [2:0]        priority_level_low,
	input wire [3:0]        priorityLevel,
	input wire              stack_frame_active,
	input wire [PAGE_W-1:0] eds_read_page,
	input wire [PAGE_W-1:0] stackReadPage,
	input wire              accWrA,
	input wire [ACC_W-1:0]  accIn,
	input wire [ACC_W-1:0]  accumulator_a,
	input wire              roundBiased,
	input wire              multInteger,
	input wire              pcLoad,
	input wire              pcStep,
	input wire [PC_W-1:0]   pcIn,
	input wire [PC_W-1:0]   programCounter
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_read_latency: assert property (clkEn && memRd ##1 clkEn |=> memRdValid)
		else $error("read answer late");
	a_valid_cause: assert property (memRdValid |-> $past(memRd, 2))
		else $error("read answer without request");
	a_prio_form: assert property (clkEn && !sys_rst |=>
		priorityLevel == $past({priority_level_msb, priority_level_low}))
		else $error("priority level wrong");
	a_page_force: assert property (clkEn && !sys_rst |=>
		stackReadPage == ($past(stack_frame_active) ? '0 : $past(eds_read_page)))
		else $error("stack page wrong");
	a_acc_load: assert property (clkEn && accWrA |=> accumulator_a == $past(accIn))
		else $error("accumulator load lost");
	a_pc_load: assert property (clkEn && pcLoad |=> programCounter == $past(pcIn))
		else $error("counter load lost");
	a_pc_step: assert property (clkEn && pcStep && !pcLoad |=>
		programCounter == PC_W'($past(programCounter) + 2))
		else $error("counter step wrong");
	a_ctl_write: assert property (clkEn && memWr && memAddr == 16'h0044 |=>
		{roundBiased, multInteger} == $past(memWrData[1:0]))
		else $error("control write lost");
	a_ctl_hold: assert property (clkEn && !(memWr && memAddr == 16'h0044) |=>
		$stable({roundBiased, multInteger}))
		else $error("control bits changed unasked");
endmodule // cpu_core_register_state_asserts
bind cpu_core_register_state cpu_core_register_state_asserts
	#(.DATA_W(DATA_W), .ACC_W(ACC_W), .PC_W(PC_W), .PAGE_W(PAGE_W))
	chk_u (.clk, .sys_rst, .clkEn, .memAddr, .memWr, .memRd, .memWrData, .memRdValid, .priority_level_msb,
	.priority_level_low, .priorityLevel, .stack_frame_active, .eds_read_page, .stackReadPage, .accWrA, .accIn,
	.accumulator_a, .roundBiased, .multInteger, .pcLoad, .pcStep, .pcIn, .programCounter);

// *** tb/cpu_core_register_state_tb_top.sv ***
/*
 Testbench for the core register state: data-port read and write tasks with expected values.
 Assumes the design port timing of a two-edge read answer and single-edge writes.
*/
`timescale 1ns/100ps
module cpu_core_register_state_tb_top;
	reg        clk = 0, sys_rst = 1, clkEn = 1, memWr = 0, memRd = 0, priority_level_msb = 0;
	reg        stack_frame_active = 0, accWrA = 0, accWrB = 0, pcLoad = 0, pcStep = 0, loopLoad = 0;
	reg [15:0] memAddr = 0, memWrData = 0;
	reg [1:0]  contextSel = 0;
	reg [2:0]  priority_level_low = 0;
	reg [9:0]  eds_read_page = 0, eds_write_page = 0;
	reg [39:0] accIn = 0;
	reg [22:0] pcIn = 0, loopStartIn = 0;
	wire [15:0] memRdData;
	wire        memRdValid, roundBiased, multInteger;
	wire [3:0]  priorityLevel;
	wire [9:0]  stackReadPage, stackWritePage;
	wire [39:0] accumulator_a, accumulator_b;
	wire [22:0] programCounter;
	integer     err_total = 0, n_compared = 0, i;
	cpu_core_register_state dut_u (.clk, .sys_rst, .clkEn, .memAddr, .memWr, .memRd, .memWrData, .memRdData,
		.memRdValid, .contextSel, .priority_level_msb, .priority_level_low, .priorityLevel, .stack_frame_active,
		.eds_read_page, .eds_write_page, .stackReadPage, .stackWritePage, .accWrA, .accWrB, .accIn, .accumulator_a,
		.accumulator_b, .roundBiased, .multInteger, .pcLoad, .pcStep, .pcIn, .programCounter, .loopLoad, .loopStartIn);
	always #20 clk = ~clk;
	task tally_and_finish;
	begin
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	task chk(input [39:0] g, input [39:0] e);
	begin
		n_compared++;
		if (g !== e)
		begin
			err_total++;
			$display("ERROR at %0t: got %h expected %h", $time, g, e);
		end
	end
	endtask
	task wr(input [15:0] a, input [15:0] d);
	begin
		@(posedge clk) {memWr, memAddr, memWrData} <= {1'b1, a, d};
		@(posedge clk) memWr <= 0;
	end
	endtask
	task rd(input [15:0] a, input [15:0] e);
		integer k;
	begin
		@(posedge clk) {memRd, memAddr} <= {1'b1, a};
		@(posedge clk) memRd <= 0;
		for (k = 0; k < 6 && memRdValid !== 1'b1; k++) @(posedge clk);
		if (memRdValid !== 1'b1)
		begin
			err_total++;
			$display("ERROR at %0t: no read answer", $time);
			tally_and_finish;
		end
		else
			chk(memRdData, e);
	end
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		sys_rst <= 0;
		rd(16'h0044, 0);
		rd(16'h002E, 0);
		chk(accumulator_a, 0);
		$display("test reset done");
		for (i = 0; i < 3; i++)
		begin
			@(posedge clk) contextSel <= i[1:0];
			wr(16'h0002, 16'hA000 + i[15:0]);
			wr(16'h001E, 16'h5000 + i[15:0]);
		end
		for (i = 0; i < 4; i++)
		begin
			@(posedge clk) contextSel <= i[1:0];
			rd(16'h0002, 16'hA000 + i % 3);
			rd(16'h001E, 16'h5002);
		end
		rd(16'h0003, 0);
		rd(16'h0100, 0);
		$display("test contexts done");
		@(posedge clk) {accIn, accWrA} <= {40'h8012345678, 1'b1};
		@(posedge clk) {accIn, accWrA, accWrB} <= {40'h7F0000BEEF, 2'b01};
		@(posedge clk) accWrB <= 0;
		rd(16'h0022, 16'h5678);
		rd(16'h0024, 16'h1234);
		rd(16'h0026, 16'hFF80);
		rd(16'h002C, 16'h007F);
		wr(16'h0028, 16'h1357);
		@(posedge clk);
		chk(accumulator_b, 40'h7F00001357);
		chk(accumulator_a, 40'h8012345678);
		$display("test accumulators done");
		@(posedge clk) {pcIn, pcLoad} <= {23'h7FFFFE, 1'b1};
		@(posedge clk) {pcLoad, pcStep} <= 2'b01;
		@(posedge clk) pcStep <= 0;
		rd(16'h002E, 0);
		wr(16'h002E, 16'h1235);
		rd(16'h002E, 16'h1234);
		wr(16'h0030, 16'h0055);
		rd(16'h0030, 16'h0055);
		@(posedge clk) {clkEn, pcStep} <= 2'b01;
		@(posedge clk) {clkEn, pcStep} <= 2'b10;
		@(posedge clk);
		chk(programCounter, 23'h551234);
		@(posedge clk) {loopStartIn, loopLoad} <= {23'h123456, 1'b1};
		@(posedge clk) loopLoad <= 0;
		wr(16'h003A, 0);
		wr(16'h003C, 0);
		rd(16'h003A, 16'h3456);
		rd(16'h003C, 16'h0012);
		$display("test counters done");
		wr(16'h0044, 16'hFFFF);
		rd(16'h0044, 16'h0003);
		chk({roundBiased, multInteger}, 3);
		@(posedge clk) {priority_level_msb, stack_frame_active, eds_read_page, eds_write_page} <= {2'b11, 20'h556AA};
		rd(16'h0044, 16'h000F);
		chk(priorityLevel, 8);
		chk({stackReadPage, stackWritePage}, 0);
		wr(16'h0044, 0);
		rd(16'h0044, 16'h000C);
		chk({roundBiased, multInteger}, 0);
		@(posedge clk) {priority_level_msb, priority_level_low, stack_frame_active} <= 5'b01110;
		rd(16'h0044, 0);
		chk(priorityLevel, 7);
		chk({stackReadPage, stackWritePage}, 20'h556AA);
		$display("test control done");
		wr(16'h0044, 16'h0003);
		@(posedge clk) sys_rst <= 1;
		repeat (3) @(posedge clk);
		sys_rst <= 0;
		rd(16'h0044, 0);
		rd(16'h0030, 0);
		rd(16'h0002, 16'hA000);
		chk(accumulator_b, 0);
		chk(priorityLevel, 7);
		$display("test reset again done");
		tally_and_finish;
	end
endmodule // cpu_core_register_state_tb_top
